// ===== hw/bcp_defs.vh
`ifndef BCP_DEFS_VH
`define BCP_DEFS_VH
// ==========================================================================
// Clock and time base
`define BCP_CLK_MHZ      20
`define BCP_TICK_US      1000
`define BCP_PULSE_US     27
`define BCP_MSW          20
// ==========================================================================
// Durations in milliseconds
`define BCP_DQ_LOW_MS    20'h0_07D0
`define BCP_SLEEP_MAX_MS 20'h0_2AF8
`define BCP_SETTLE_MS    20'h0_03E8
`define BCP_CONV_MS      20'h0_006E
`define BCP_TEST_MS      20'h0_0037
`define BCP_HOLD_MS      20'h0_036B
`define BCP_DECAY_MS     20'h0_3345
`define BCP_BLANK_MS     20'h4_93E0
`define BCP_SUSTAIN_MS   20'h2_9040
`define BCP_CTR_MS       20'h0_DAC0
`define BCP_RATE_MS      20'h1_86A0
// ==========================================================================
// Voltage codes, 4.88 mV per step
`define BCP_V_LB         10'h267
`define BCP_V_CV_DEF     10'h35D
// ==========================================================================
// Temperature codes, 0.125 degC per step, two's complement
`define BCP_T_CL         11'sh000
`define BCP_T_CH         11'sh140
`define BCP_MAX_CHARGE_TEMP        11'sh190
`define BCP_T_5C         11'sh028
`define BCP_T_15C        11'sh078
// ==========================================================================
// Rise over one rate window, in temperature codes
`define BCP_RISE_LO      8'h04
`define BCP_RISE_MID     8'h06
`define BCP_RISE_HI      8'h08
`define BCP_AVG_SHIFT    3
// ==========================================================================
// Command codes
`define BCP_CMD_START    8'hB5
`define BCP_CMD_STOP     8'hBE
`define BCP_CMD_REFRESH  8'h63
// ==========================================================================
// Register word indices
`define BCP_REG_STATUS   4'h1
`define BCP_REG_CTR      4'h6
`define BCP_REG_CMD      4'h8
`define BCP_REG_VCV      4'h9
`define BCP_REG_STATE    4'hA
// ==========================================================================
// Status byte fields
`define BCP_ST_HI        7
`define BCP_ST_LO        6
`define BCP_ST_PERMIT    5
`define BCP_ST_AUTO      4
`define BCP_ST_CHEM      3
`define BCP_ST_RSV_MSB   2
`endif

// ===== hw/bcp_rate.v
`include "bcp_defs.vh"
`default_nettype none
// ==========================================================================
// Averaged temperature rise detector
module bcp_rate #(
  parameter [`BCP_MSW-1:0] WIN_MS = `BCP_RATE_MS
) (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rst,
  // Timing and control
  input  wire        i_tick,
  input  wire        i_clear,
  // Measurements
  input  wire        i_meas,
  input  wire [10:0] i_temp,
  input  wire [7:0]  i_thr,
  // Result
  output reg         o_rate_high
);

  reg  signed [13:0]        avg;
  reg  signed [13:0]        prev;
  reg         [`BCP_MSW-1:0] win;
  wire signed [13:0]        tx8   = {i_temp, 3'b000};
  wire signed [14:0]        err   = {tx8[13], tx8} - {avg[13], avg};
  wire signed [14:0]        step  = err >>> `BCP_AVG_SHIFT;
  wire signed [14:0]        delta = {avg[13], avg} - {prev[13], prev};
  wire signed [14:0]        thr8  = {4'h0, i_thr, 3'b000};

  // Smoothing keeps single noisy conversions from tripping the detector.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      avg         <= 14'sh0000;
      prev        <= 14'sh0000;
      win         <= {`BCP_MSW{1'b0}};
      o_rate_high <= 1'b0;
    end else if (i_clear) begin
      avg         <= tx8;
      prev        <= tx8;
      win         <= {`BCP_MSW{1'b0}};
      o_rate_high <= 1'b0;
    end else begin
      if (i_meas) begin
        avg <= avg + step[13:0];
      end
      if (i_tick) begin
        if (win == WIN_MS - 1'b1) begin
          win         <= {`BCP_MSW{1'b0}};
          prev        <= avg;
          o_rate_high <= (delta >= thr8);
        end else begin
          win <= win + 1'b1;
        end
      end
    end
  end

endmodule // bcp_rate
`default_nettype wire

// ===== hw/bcp_tick.v
`include "bcp_defs.vh"
`default_nettype none
// ==========================================================================
// Millisecond enable divider
module bcp_tick #(
  parameter [15:0] TICK_CYC = 16'h4E20
) (
  // Clock and reset
  input  wire i_mclk,
  input  wire i_rst,
  // One-cycle enable once per period
  output reg  o_tick
);

  reg [15:0] cnt;

  // Free-running divider; every slow timer hangs off this enable.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt == TICK_CYC - 16'h0001) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 16'h0001;
      o_tick <= 1'b0;
    end
  end

endmodule // bcp_tick
`default_nettype wire

// ===== hw/bcp_top.v
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`include "bcp_defs.vh"
`default_nettype none
// ==========================================================================
// Battery charge and power-mode controller
module bcp_top #(
  parameter [15:0]          P_TICK_CYC    = `BCP_CLK_MHZ * `BCP_TICK_US,
  parameter [`BCP_MSW-1:0]  P_DQ_LOW_MS   = `BCP_DQ_LOW_MS,
  parameter [`BCP_MSW-1:0]  P_SETTLE_MS   = `BCP_SETTLE_MS,
  parameter [`BCP_MSW-1:0]  P_CONV_MS     = `BCP_CONV_MS,
  parameter [`BCP_MSW-1:0]  P_TEST_MS     = `BCP_TEST_MS,
  parameter [`BCP_MSW-1:0]  P_HOLD_MS     = `BCP_HOLD_MS,
  parameter [`BCP_MSW-1:0]  P_DECAY_MS    = `BCP_DECAY_MS,
  parameter [`BCP_MSW-1:0]  P_BLANK_MS    = `BCP_BLANK_MS,
  parameter [`BCP_MSW-1:0]  P_SUSTAIN_MS  = `BCP_SUSTAIN_MS,
  parameter [`BCP_MSW-1:0]  P_CTR_MS      = `BCP_CTR_MS,
  parameter [`BCP_MSW-1:0]  P_RATE_MS     = `BCP_RATE_MS
) (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rst,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // Measurements and sense inputs
  input  wire        i_meas_strobe,
  input  wire [9:0]  i_volt,
  input  wire [10:0] i_temp,
  input  wire        i_charger_present,
  input  wire        i_dq,
  // Nonvolatile initialization bytes
  input  wire [7:0]  i_nv_status_init,
  input  wire [7:0]  i_nv_charge_time,
  // Charge gates and power mode
  output reg         o_fast_gate_n,
  output reg         o_trickle_gate_n,
  output reg         o_sleep
);

  // ========================================================================
  // State codes
  localparam [2:0] CH_IDLE  = 3'h0;
  localparam [2:0] CH_PEND  = 3'h1;
  localparam [2:0] CH_BULK  = 3'h2;
  localparam [2:0] CH_HOLD  = 3'h3;
  localparam [2:0] CH_DECAY = 3'h4;
  localparam [2:0] CH_NIMH  = 3'h5;
  localparam [1:0] PW_ACTIVE = 2'h0;
  localparam [1:0] PW_ENTER  = 2'h1;
  localparam [1:0] PW_SLEEP  = 2'h2;
  localparam [9:0] PULSE_CYC = `BCP_CLK_MHZ * `BCP_PULSE_US;

  // ========================================================================
  // Declarations
  wire               tick;
  wire               rate_high;
  reg                init_done;
  reg                sleep_permit;
  reg                charger_auto_start;
  reg                chemistry_select;
  reg                done_flag;
  reg  [7:0]         charge_time_counter;
  reg  [9:0]         charge_voltage_threshold;
  reg  [2:0]         chg_st;
  reg  [1:0]         pw_st;
  reg                chg_prev;
  reg  [7:0]         rise_thr;
  reg  [`BCP_MSW-1:0] dq_cnt;
  reg  [`BCP_MSW-1:0] settle_cnt;
  reg  [`BCP_MSW-1:0] conv_cnt;
  reg  [`BCP_MSW-1:0] test_cnt;
  reg  [`BCP_MSW-1:0] phase_cnt;
  reg  [`BCP_MSW-1:0] fast_ms;
  reg  [`BCP_MSW-1:0] sus_cnt;
  reg  [`BCP_MSW-1:0] ctr_ms;
  reg  [9:0]         pulse_cyc;
  reg  [31:0]        next_rdata;
  wire [7:0]         status_byte;

  // ========================================================================
  // Time base and rise detector
  bcp_tick #(
    .TICK_CYC (P_TICK_CYC)
  ) u_tick (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .o_tick (tick)
  );

  wire fast_start;
  wire asleep = (pw_st == PW_SLEEP);

  bcp_rate #(
    .WIN_MS (P_RATE_MS)
  ) u_rate (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_tick      (tick),
    .i_clear     (fast_start),
    .i_meas      (i_meas_strobe & ~asleep),
    .i_temp      (i_temp),
    .i_thr       (rise_thr),
    .o_rate_high (rate_high)
  );

  // ========================================================================
  // Bus decode; a write lands on the edge that sees waitrequest low.
  wire       bus_wr  = i_avs_write & ~o_avs_waitrequest;
  wire       wr_lo   = bus_wr & i_avs_byteenable[0];
  wire [7:0] wbyte   = i_avs_writedata[7:0];
  wire       wr_stat = wr_lo & (i_avs_address == `BCP_REG_STATUS);
  wire       wr_ctr  = wr_lo & (i_avs_address == `BCP_REG_CTR);
  wire       wr_cmd  = wr_lo & (i_avs_address == `BCP_REG_CMD);
  wire       wr_vcv  = bus_wr & (i_avs_address == `BCP_REG_VCV);
  wire       cmd_start   = wr_cmd & (wbyte == `BCP_CMD_START);
  wire       cmd_stop    = wr_cmd & (wbyte == `BCP_CMD_STOP);
  wire       cmd_refresh = wr_cmd & (wbyte == `BCP_CMD_REFRESH);

  // ========================================================================
  // Conditions seen by one or both state machines
  wire signed [10:0] temp_s = i_temp;
  wire volt_low  = (i_volt < `BCP_V_LB);
  wire at_cv     = (i_volt >= charge_voltage_threshold);
  wire temp_ok   = (temp_s >= `BCP_T_CL) && (temp_s <= `BCP_T_CH);
  wire over_temp = (temp_s > `BCP_MAX_CHARGE_TEMP);
  wire conv_ok   = (conv_cnt == P_CONV_MS);
  wire chg_rise  = i_charger_present & ~chg_prev;
  wire long_low  = (dq_cnt > P_DQ_LOW_MS);
  wire fast      = (chg_st == CH_BULK) || (chg_st == CH_HOLD) ||
                   (chg_st == CH_DECAY) || (chg_st == CH_NIMH);
  wire gate_low  = fast && (chg_st != CH_DECAY);
  wire sleep_cond  = sleep_permit & long_low & (pw_st == PW_ACTIVE);
  wire sleep_abort = sleep_cond & ~charger_auto_start;
  wire initiate  = cmd_start | (chg_rise & charger_auto_start);
  wire start_ok  = i_charger_present & temp_ok & conv_ok &
                   ~volt_low;
  wire pend_drop = cmd_stop | sleep_abort | (pw_st == PW_ENTER);
  assign fast_start = (chg_st == CH_PEND) & ~pend_drop & start_ok;
  wire abort_fast = fast & (~i_charger_present | cmd_stop |
                            sleep_abort);
  wire li_done  = (chg_st == CH_DECAY) && (phase_cnt > P_DECAY_MS);
  wire ni_done  = (chg_st == CH_NIMH) &&
                  (sus_cnt >= P_SUSTAIN_MS);
  wire ctr_done = (charge_time_counter == 8'h00);
  wire terminate = fast & ~abort_fast &
                   (over_temp | ctr_done | li_done | ni_done);
  wire ctr_step  = tick & (ctr_ms == P_CTR_MS - 1'b1);

  // ========================================================================
  // Configuration bits. The reset cannot sample the nonvolatile byte, so it
  // is copied on the first clock after release instead.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      init_done          <= 1'b0;
      sleep_permit       <= 1'b0;
      charger_auto_start <= 1'b0;
      chemistry_select   <= 1'b0;
    end else if (~init_done | cmd_refresh) begin
      init_done          <= 1'b1;
      sleep_permit       <= i_nv_status_init[`BCP_ST_PERMIT];
      charger_auto_start <= i_nv_status_init[`BCP_ST_AUTO];
      chemistry_select   <= i_nv_status_init[`BCP_ST_CHEM];
    end
  end

  // Done latch; a completion in the clearing cycle still sets it.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      done_flag <= 1'b0;
    end else begin
      done_flag <= terminate | (done_flag & ~wr_stat);
    end
  end

  // Charge-voltage threshold, writable so one design serves either cell.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      charge_voltage_threshold <= `BCP_V_CV_DEF;
    end else if (wr_vcv) begin
      if (i_avs_byteenable[0]) begin
        charge_voltage_threshold[7:0] <= wbyte;
      end
      if (i_avs_byteenable[1]) begin
        charge_voltage_threshold[9:8] <= i_avs_writedata[9:8];
      end
    end
  end

  // ========================================================================
  // Power-mode machine
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pw_st      <= PW_ACTIVE;
      settle_cnt <= {`BCP_MSW{1'b0}};
      dq_cnt     <= {`BCP_MSW{1'b0}};
      conv_cnt   <= {`BCP_MSW{1'b0}};
      chg_prev   <= 1'b0;
      o_sleep    <= 1'b0;
    end else begin
      chg_prev <= i_charger_present;
      o_sleep  <= asleep;
      // The low-time counter saturates one past the limit.
      if (i_dq) begin
        dq_cnt <= {`BCP_MSW{1'b0}};
      end else if (tick && !long_low) begin
        dq_cnt <= dq_cnt + 1'b1;
      end
      // Conversions are trusted only after P_CONV_MS ms awake.
      if (asleep) begin
        conv_cnt <= {`BCP_MSW{1'b0}};
      end else if (tick && !conv_ok) begin
        conv_cnt <= conv_cnt + 1'b1;
      end
      case (pw_st)
        PW_ACTIVE: begin
          if (sleep_cond && (!charger_auto_start || !fast)) begin
            pw_st      <= PW_ENTER;
            settle_cnt <= {`BCP_MSW{1'b0}};
          end
        end
        PW_ENTER: begin
          if (i_dq) begin
            pw_st <= PW_ACTIVE;
          end else if (settle_cnt == P_SETTLE_MS) begin
            pw_st <= PW_SLEEP;
          end else if (tick) begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
        PW_SLEEP: begin
          if (i_dq || (charger_auto_start && chg_rise)) begin
            pw_st  <= PW_ACTIVE;
            dq_cnt <= {`BCP_MSW{1'b0}};
          end
        end
        default: begin
          pw_st <= PW_ACTIVE;
        end
      endcase
    end
  end

  // ========================================================================
  // Charge machine
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      chg_st    <= CH_IDLE;
      phase_cnt <= {`BCP_MSW{1'b0}};
      fast_ms   <= {`BCP_MSW{1'b0}};
      sus_cnt   <= {`BCP_MSW{1'b0}};
      rise_thr  <= `BCP_RISE_HI;
    end else begin
      case (chg_st)
        CH_IDLE: begin
          if (initiate) begin
            chg_st <= CH_PEND;
          end
        end
        CH_PEND: begin
          if (pend_drop) begin
            chg_st <= CH_IDLE;
          end else if (fast_start) begin
            phase_cnt <= {`BCP_MSW{1'b0}};
            fast_ms   <= {`BCP_MSW{1'b0}};
            sus_cnt   <= {`BCP_MSW{1'b0}};
            chg_st    <= chemistry_select ? CH_NIMH : CH_BULK;
            if (temp_s < `BCP_T_5C) begin
              rise_thr <= `BCP_RISE_LO;
            end else if (temp_s < `BCP_T_15C) begin
              rise_thr <= `BCP_RISE_MID;
            end else begin
              rise_thr <= `BCP_RISE_HI;
            end
          end
        end
        CH_BULK: begin
          if (abort_fast || terminate) begin
            chg_st <= CH_IDLE;
          end else if (at_cv) begin
            chg_st    <= CH_HOLD;
            phase_cnt <= {`BCP_MSW{1'b0}};
          end
        end
        CH_HOLD: begin
          if (abort_fast || terminate) begin
            chg_st <= CH_IDLE;
          end else if (phase_cnt == P_HOLD_MS) begin
            chg_st    <= CH_DECAY;
            phase_cnt <= {`BCP_MSW{1'b0}};
          end else if (tick) begin
            phase_cnt <= phase_cnt + 1'b1;
          end
        end
        CH_DECAY: begin
          if (abort_fast || terminate) begin
            chg_st <= CH_IDLE;
          end else if (!at_cv) begin
            chg_st <= CH_BULK;
          end else if (tick) begin
            phase_cnt <= phase_cnt + 1'b1;
          end
        end
        CH_NIMH: begin
          if (abort_fast || terminate) begin
            chg_st <= CH_IDLE;
          end else if (tick) begin
            if (fast_ms < P_BLANK_MS) begin
              fast_ms <= fast_ms + 1'b1;
              sus_cnt <= {`BCP_MSW{1'b0}};
            end else if (rate_high) begin
              sus_cnt <= sus_cnt + 1'b1;
            end else begin
              sus_cnt <= {`BCP_MSW{1'b0}};
            end
          end
        end
        default: begin
          chg_st <= CH_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Charge timer; a host write wins over the load and the decrement.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      charge_time_counter <= 8'h00;
      ctr_ms              <= {`BCP_MSW{1'b0}};
    end else begin
      if (!fast || ctr_step) begin
        ctr_ms <= {`BCP_MSW{1'b0}};
      end else if (tick) begin
        ctr_ms <= ctr_ms + 1'b1;
      end
      if (wr_ctr) begin
        charge_time_counter <= wbyte;
      end else if (fast_start) begin
        charge_time_counter <= i_nv_charge_time;
      end else if (fast && ctr_step && !ctr_done) begin
        charge_time_counter <= charge_time_counter - 8'h01;
      end
    end
  end

  // ========================================================================
  // Removal-test pulse on the fast gate.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      test_cnt  <= {`BCP_MSW{1'b0}};
      pulse_cyc <= 10'h000;
    end else if (!fast) begin
      test_cnt  <= {`BCP_MSW{1'b0}};
      pulse_cyc <= 10'h000;
    end else begin
      if (pulse_cyc != 10'h000) begin
        pulse_cyc <= pulse_cyc - 10'h001;
      end
      if (tick) begin
        if (test_cnt == P_TEST_MS - 1'b1) begin
          test_cnt  <= {`BCP_MSW{1'b0}};
          pulse_cyc <= PULSE_CYC;
        end else begin
          test_cnt <= test_cnt + 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Gate outputs, both registered.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fast_gate_n    <= 1'b1;
      o_trickle_gate_n <= 1'b1;
    end else begin
      o_fast_gate_n    <= ~gate_low | (pulse_cyc != 10'h000) |
                          abort_fast | terminate;
      o_trickle_gate_n <= ~(i_charger_present & volt_low &
                            ~asleep);
    end
  end

  // ========================================================================
  // Status byte and read mux
  assign status_byte[`BCP_ST_HI]     = done_flag;
  assign status_byte[`BCP_ST_LO]     = done_flag | fast |
                                       ~o_trickle_gate_n;
  assign status_byte[`BCP_ST_PERMIT] = sleep_permit;
  assign status_byte[`BCP_ST_AUTO]   = charger_auto_start;
  assign status_byte[`BCP_ST_CHEM]   = chemistry_select;
  assign status_byte[`BCP_ST_RSV_MSB:0] = 3'h0;

  always @* begin
    case (i_avs_address)
      `BCP_REG_STATUS: next_rdata = {24'h00_0000, status_byte};
      `BCP_REG_CTR:    next_rdata = {24'h00_0000, charge_time_counter};
      `BCP_REG_VCV:    next_rdata = {22'h00_0000, charge_voltage_threshold};
      `BCP_REG_STATE:  next_rdata = {27'h000_0000, pw_st, chg_st};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access keeps read data on a flop.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata    <= next_rdata;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

endmodule // bcp_top
`default_nettype wire

// ===== tb/battery_charge_power_controller_tb.sv
`default_nettype none
// ====================
// Bench
module battery_charge_power_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rd = 0, wr = 0, hold = 0, chg = 0;
  logic [3:0] adr = 0, be = 4'hF;
  logic meas = 0;
  logic [7:0] nvs = 8'h20, nvt = 8'h40;
  logic [31:0] wd = 0, rdat, rdata;
  logic [9:0] volt = 10'h200;
  logic [10:0] temp = 11'h0C8;
  logic waitreq, fast_n, tric_n, sleep, dq;
  int error_cnt = 0, samples_checked = 0;
  // Clock at 20 MHz.
  always #25 clk = ~clk;
  bcp_host_mdl host (.i_mclk(clk), .i_hold_low(hold), .o_dq(dq));
  // Shorter millisecond tick keeps the run well inside the cycle budget.
  bcp_top #(.P_TICK_CYC(16'h03E8), .P_DQ_LOW_MS(20'h0_0014),
    .P_SETTLE_MS(20'h0_0005), .P_CONV_MS(20'h0_0003),
    .P_TEST_MS(20'h0_0005)) dut (
    .i_mclk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_meas_strobe(meas), .i_volt(volt), .i_temp(temp),
    .i_charger_present(chg), .i_dq(dq), .i_nv_status_init(nvs),
    .i_nv_charge_time(nvt), .o_fast_gate_n(fast_n),
    .o_trickle_gate_n(tric_n), .o_sleep(sleep));
  task automatic conclude();
    $display("compares %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a level; running out ends the run as a failure.
  task automatic await_lvl(ref logic s, input logic v, input int lim);
    repeat (lim) if (s !== v) @(posedge clk);
    if (s !== v) begin
      error_cnt++;
      conclude();
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    @(posedge clk);
    await_lvl(waitreq, 1'b0, 20);
    rdat = rdata;
    {wr, rd} <= 2'b00;
    @(posedge clk);
  endtask
  // Charge, stop and sleep sequences.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("sleep", 0, sleep);
    bus(0, 4'h1, 0);
    chk("config", 32'h20, rdat & 32'h38);
    chg <= 1;
    repeat (4) @(posedge clk);
    chk("trickle", 0, tric_n);
    bus(0, 4'h1, 0);
    chk("progress", 32'h40, rdat & 32'hC0);
    bus(1, 4'h8, 32'hB5);
    repeat (40) @(posedge clk);
    chk("postponed", 1, fast_n);
    volt <= 10'h300;
    await_lvl(fast_n, 1'b0, 5000);
    chk("trickle", 1, tric_n);
    bus(0, 4'h6, 0);
    chk("timer", 32'h40, rdat);
    temp <= 11'h1A0;
    await_lvl(fast_n, 1'b1, 20);
    bus(0, 4'h1, 0);
    chk("done", 32'hC0, rdat & 32'hC0);
    temp <= 11'h0C8;
    bus(1, 4'h1, 32'h20);
    bus(0, 4'h1, 0);
    chk("cleared", 0, rdat & 32'hC0);
    bus(1, 4'h8, 32'hB5);
    await_lvl(fast_n, 1'b0, 100);
    bus(1, 4'h8, 32'hBE);
    await_lvl(fast_n, 1'b1, 20);
    bus(0, 4'h1, 0);
    chk("stopped", 0, rdat & 32'hC0);
    chg <= 0;
    hold <= 1;
    repeat (15000) @(posedge clk);
    chk("awake", 0, sleep);
    await_lvl(sleep, 1'b1, 15000);
    hold <= 0;
    await_lvl(sleep, 1'b0, 20);
    conclude();
  end
endmodule // battery_charge_power_controller_tb
`default_nettype wire

// ===== tb/bcp_host_mdl.sv
`default_nettype none
// ====================
// Host on the serial data line
module bcp_host_mdl (
  input  wire logic i_mclk,
  input  wire logic i_hold_low,
  output var  logic o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  // The host only moves the line just after an edge, idle high.
  initial o_dq = 1'b1;
  always @(posedge i_mclk) o_dq <= !i_hold_low;
endmodule // bcp_host_mdl
`default_nettype wire

// ===== tb/bcp_top_sva.sv
`default_nettype none
// ====================
// Port checker
module bcp_top_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic [9:0]  i_volt,
  input wire logic [10:0] i_temp,
  input wire logic        i_charger_present,
  input wire logic        i_dq,
  input wire logic        o_fast_gate_n,
  input wire logic        o_trickle_gate_n,
  input wire logic        o_sleep
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_weak;
    i_charger_present && i_volt < 10'h267 && !o_sleep;
  endsequence
  // Margins of a few cycles allow for the registered outputs.
  chk_bus_answer: assert property (s_req |=> !o_avs_waitrequest)
    else $error("bus answer late");
  chk_trickle_on: assert property (
    s_weak [*3] ##1 !o_sleep |-> !o_trickle_gate_n) else $error("trickle off");
  chk_trickle_dry: assert property (
    (!i_charger_present) [*3] |-> o_trickle_gate_n) else $error("trickle on");
  chk_sleep_cause: assert property ($rose(o_sleep) |-> !$past(i_dq))
    else $error("sleep without low line");
  chk_line_wake: assert property (o_sleep && i_dq |-> ##[1:8] !o_sleep)
    else $error("no wake on line high");
  chk_fast_removal: assert property (
    (!i_charger_present) [*5] |-> o_fast_gate_n) else $error("gate on dry");
  chk_fast_hot: assert property (
    ($signed(i_temp) > 11'sh190) [*5] |-> o_fast_gate_n) else $error("hot");
  chk_start_cond: assert property (
    $fell(o_fast_gate_n) |-> $past(i_charger_present, 2))
    else $error("fast start without charger");
endmodule // bcp_top_sva
bind bcp_top bcp_top_sva u_sva (.i_mclk, .i_rst, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_volt, .i_temp, .i_charger_present, .i_dq,
  .o_fast_gate_n, .o_trickle_gate_n, .o_sleep);
`default_nettype wire
